/* rtl/acs_conversion_sequencer.sv */
`timescale 1ns/10ps
module acs_conversion_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_sys_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic      [DATA_W-1:0] o_rd_data,
    // Compare module
    input  wire logic [3:0]        i_compare_mode_select,
    input  wire logic              i_special_event,
    output logic                   o_ref_counter_clear,
    // Power and conversion clock
    input  wire logic              i_sleep,
    input  wire logic              i_rc_tick,
    output logic                   o_converter_powered,
    output logic                   o_wake,
    // Analog comparator and trial code
    input  wire logic              i_cmp_high,
    output logic      [11:0]       o_dac_code
);
    // Phase and divider group
    logic [1:0] qphase;
    logic [1:0] next_qphase;
    logic [4:0] osc_div;
    logic [4:0] next_osc_div;
    logic       trig_pend;
    logic       next_trig_pend;
    logic       in_second_quarter;
    logic       trig_act;
    logic       tad_tick;
    // Control group
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] peripheral_irq_enables;
    logic [7:0] vref_control;
    logic [7:0] adc_control_main;
    logic [7:0] adc_control_config;
    logic [7:0] next_interrupt_control;
    logic [7:0] next_peripheral_irq_flags;
    logic [7:0] next_peripheral_irq_enables;
    logic [7:0] next_vref_control;
    logic [7:0] next_adc_control_main;
    logic [7:0] next_adc_control_config;
    logic       converter_on;
    logic       convert_go;
    logic [1:0] conv_clock_select;
    logic       conv_done_irq_enable;
    // Sequencer group
    acs_state_e  state;
    acs_state_e  next_state;
    logic [11:0] sar;
    logic [11:0] next_sar;
    logic [11:0] trial;
    logic [11:0] next_trial;
    logic [1:0]  rc_cnt;
    logic [1:0]  next_rc_cnt;
    logic        pd_latch;
    logic        next_pd_latch;
    logic [7:0]  result_high_byte;
    logic [7:0]  result_low_byte;
    logic [7:0]  next_result_high_byte;
    logic [7:0]  next_result_low_byte;
    logic [7:0]  next_rd_data;
    logic [11:0] next_dac_code;
    logic        next_ref_counter_clear;
    logic        next_converter_powered;
    logic        next_wake;
    logic        busy;
    logic        sleep_abort;
    logic        finish;
    logic        load;
    logic [11:0] load_val;
    assign converter_on         = adc_control_main[CM_CONVERTER_ON];
    assign convert_go           = adc_control_main[CM_CONVERT_GO];
    assign conv_clock_select    = adc_control_main[CM_CONV_CLOCK_SELECT +: 2];
    assign conv_done_irq_enable = peripheral_irq_enables[PIE_CONV_DONE_IRQ_EN];
    function automatic logic [15:0] fmt_result(input logic [11:0] v, input logic right_just);
        if (right_just) begin
            fmt_result = {4'h0, v};
        end else begin
            fmt_result = {v, 4'h0};
        end
    endfunction
    // Quarter phases, oscillator divider, trigger alignment
    always_comb begin
        next_qphase       = qphase + 2'h1;
        next_osc_div      = osc_div + 5'h01;
        in_second_quarter = (qphase == SECOND_QUARTER_PHASE);
        // Trigger held pending so go always rises out of the second quarter
        trig_act          = in_second_quarter && (trig_pend || i_special_event) &&
                            (i_compare_mode_select == TRIGGER_MODE_CODE);
        next_trig_pend    = (trig_pend || i_special_event) && !in_second_quarter;
        case (conv_clock_select)
            CLKSEL_DIV2:  tad_tick = ((osc_div & DIV2_MASK) == DIV2_MASK);
            CLKSEL_DIV8:  tad_tick = ((osc_div & DIV8_MASK) == DIV8_MASK);
            CLKSEL_DIV32: tad_tick = ((osc_div & DIV32_MASK) == DIV32_MASK);
            default:      tad_tick = i_rc_tick;
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            qphase    <= 2'h0;
            osc_div   <= 5'h00;
            trig_pend <= 1'b0;
        end else begin
            qphase    <= next_qphase;
            osc_div   <= next_osc_div;
            trig_pend <= next_trig_pend;
        end
    end
    // Control registers
    always_comb begin
        next_interrupt_control      = interrupt_control;
        next_peripheral_irq_flags   = peripheral_irq_flags;
        next_peripheral_irq_enables = peripheral_irq_enables;
        next_vref_control           = vref_control;
        next_adc_control_main       = adc_control_main;
        next_adc_control_config     = adc_control_config;
        if (i_wr_stb) begin
            case (i_addr)
                OFS_INTERRUPT_CONTROL:  next_interrupt_control      = i_wr_data;
                OFS_PERIPH_IRQ_FLAGS:   next_peripheral_irq_flags   = i_wr_data;
                OFS_PERIPH_IRQ_ENABLES: next_peripheral_irq_enables = i_wr_data;
                OFS_VREF_CONTROL:       next_vref_control           = i_wr_data & VREF_IMPL_MASK;
                OFS_ADC_CONTROL_CONFIG: next_adc_control_config     = i_wr_data;
                OFS_ADC_CONTROL_MAIN: begin
                    next_adc_control_main = i_wr_data;
                    // Go only sticks if the converter was already on and stays on
                    next_adc_control_main[CM_CONVERT_GO] = i_wr_data[CM_CONVERT_GO] && converter_on &&
                                                           i_wr_data[CM_CONVERTER_ON];
                end
                default: ;
            endcase
        end
        if (state == ACS_FINISH || sleep_abort) begin
            next_adc_control_main[CM_CONVERT_GO] = 1'b0;
        end
        // Hardware set wins over a same-cycle software clear
        if (trig_act && converter_on) begin
            next_adc_control_main[CM_CONVERT_GO] = 1'b1;
        end
        if (finish) begin
            next_peripheral_irq_flags[PIR_CONV_DONE_IRQ_FLAG] = 1'b1;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            interrupt_control      <= RST_CONTROL;
            peripheral_irq_flags   <= RST_CONTROL;
            peripheral_irq_enables <= RST_CONTROL;
            vref_control           <= RST_CONTROL;
            adc_control_main       <= RST_CONTROL;
            adc_control_config     <= RST_CONTROL;
        end else begin
            interrupt_control      <= next_interrupt_control;
            peripheral_irq_flags   <= next_peripheral_irq_flags;
            peripheral_irq_enables <= next_peripheral_irq_enables;
            vref_control           <= next_vref_control;
            adc_control_main       <= next_adc_control_main;
            adc_control_config     <= next_adc_control_config;
        end
    end
    // Conversion sequencer
    always_comb begin
        busy        = (state == ACS_RC_WAIT) || (state == ACS_SETTLE) ||
                      (state == ACS_CONVERT) || (state == ACS_DONE_WAIT);
        // Other clock sources stop in sleep, so the conversion cannot survive
        sleep_abort = busy && i_sleep && (conv_clock_select != CLKSEL_RC);
        finish      = (state == ACS_DONE_WAIT) && tad_tick && convert_go && converter_on && !sleep_abort;
        next_state  = state;
        next_sar    = sar;
        next_trial  = trial;
        next_rc_cnt = rc_cnt;
        load        = 1'b0;
        load_val    = sar;
        next_wake   = 1'b0;
        next_pd_latch = pd_latch && i_sleep;
        case (state)
            ACS_IDLE: begin
                if (convert_go && converter_on) begin
                    next_sar    = 12'h000;
                    next_trial  = 12'h000;
                    next_rc_cnt = 2'h0;
                    // Acquisition is software's job, same for every resolution
                    next_state  = (conv_clock_select == CLKSEL_RC) ? ACS_RC_WAIT : ACS_SETTLE;
                end
            end
            ACS_RC_WAIT: begin
                if (rc_cnt == RC_WAIT_LAST) begin
                    next_state = ACS_SETTLE;
                end else begin
                    next_rc_cnt = rc_cnt + 2'h1;
                end
            end
            ACS_SETTLE: begin
                if (tad_tick) begin
                    next_state = ACS_CONVERT;
                    next_trial = FIRST_TRIAL_BIT;
                end
            end
            ACS_CONVERT: begin
                if (tad_tick) begin
                    if (i_cmp_high) begin
                        next_sar = sar | trial;
                    end
                    next_trial = trial >> 1;
                    if (trial[0]) begin
                        next_state = ACS_DONE_WAIT;
                    end
                end
            end
            ACS_DONE_WAIT: begin
                if (finish) begin
                    next_state = ACS_FINISH;
                    load       = 1'b1;
                    if (i_sleep && conv_done_irq_enable) begin
                        next_wake = 1'b1;
                    end
                    if (i_sleep && !conv_done_irq_enable) begin
                        next_pd_latch = 1'b1;
                    end
                end
            end
            ACS_FINISH: begin
                next_state = ACS_IDLE;
            end
            default: begin
                next_state = ACS_IDLE;
            end
        endcase
        if (busy && (!convert_go || !converter_on)) begin
            // Undecided bits are still zero in sar
            next_state = ACS_IDLE;
            next_trial = 12'h000;
            load       = !convert_go;
        end
        if (sleep_abort) begin
            next_state    = ACS_IDLE;
            next_trial    = 12'h000;
            load          = 1'b0;
            next_pd_latch = 1'b1;
        end
        next_dac_code = next_sar | next_trial;
        {next_result_high_byte, next_result_low_byte} = {result_high_byte, result_low_byte};
        if (i_wr_stb && i_addr == OFS_ADC_RESULT_HIGH) begin
            next_result_high_byte = i_wr_data;
        end
        if (i_wr_stb && i_addr == OFS_ADC_RESULT_LOW) begin
            next_result_low_byte = i_wr_data;
        end
        if (load) begin
            {next_result_high_byte, next_result_low_byte} =
                fmt_result(load_val, adc_control_config[CFG_RIGHT_JUSTIFY]);
        end
        if (i_sys_rst) begin
            {next_result_high_byte, next_result_low_byte} = {result_high_byte, result_low_byte};
        end
        next_ref_counter_clear = trig_act;
        next_converter_powered = next_adc_control_main[CM_CONVERTER_ON] && !next_pd_latch &&
                                 !(i_sleep && (conv_clock_select != CLKSEL_RC));
        next_rd_data = 8'h00;
        if (i_rd_stb) begin
            case (i_addr)
                OFS_INTERRUPT_CONTROL:  next_rd_data = interrupt_control;
                OFS_PERIPH_IRQ_FLAGS:   next_rd_data = peripheral_irq_flags;
                OFS_ADC_RESULT_HIGH:    next_rd_data = result_high_byte;
                OFS_ADC_CONTROL_MAIN:   next_rd_data = adc_control_main;
                OFS_PERIPH_IRQ_ENABLES: next_rd_data = peripheral_irq_enables;
                OFS_VREF_CONTROL:       next_rd_data = vref_control;
                OFS_ADC_RESULT_LOW:     next_rd_data = result_low_byte;
                OFS_ADC_CONTROL_CONFIG: next_rd_data = adc_control_config;
                default:                next_rd_data = 8'h00;
            endcase
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state               <= ACS_IDLE;
            sar                 <= 12'h000;
            trial               <= 12'h000;
            rc_cnt              <= 2'h0;
            pd_latch            <= 1'b0;
            o_rd_data           <= 8'h00;
            o_dac_code          <= 12'h000;
            o_ref_counter_clear <= 1'b0;
            o_converter_powered <= 1'b0;
            o_wake              <= 1'b0;
        end else begin
            state               <= next_state;
            sar                 <= next_sar;
            trial               <= next_trial;
            rc_cnt              <= next_rc_cnt;
            pd_latch            <= next_pd_latch;
            o_rd_data           <= next_rd_data;
            o_dac_code          <= next_dac_code;
            o_ref_counter_clear <= next_ref_counter_clear;
            o_converter_powered <= next_converter_powered;
            o_wake              <= next_wake;
        end
        // Result bytes have no reset on purpose
        result_high_byte <= next_result_high_byte;
        result_low_byte  <= next_result_low_byte;
    end
    // Helper: conversion periods counted since the start of settling
    logic [3:0] conv_tads;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || state == ACS_IDLE || state == ACS_RC_WAIT) begin
            conv_tads <= 4'h0;
        end else if (tad_tick && conv_tads != 4'hf) begin
            conv_tads <= conv_tads + 4'h1;
        end
    end
    property p_trigger_go;
        @(posedge i_clock) disable iff (i_sys_rst)
        trig_act && converter_on |=> convert_go;
    endproperty
    a_trigger_go: assert property (p_trigger_go) else $error("trigger did not set go");
    property p_trigger_clear;
        @(posedge i_clock) disable iff (i_sys_rst)
        in_second_quarter && (trig_pend || i_special_event) && i_compare_mode_select == TRIGGER_MODE_CODE
        |=> o_ref_counter_clear ##1 !o_ref_counter_clear;
    endproperty
    a_trigger_clear: assert property (p_trigger_clear) else $error("counter clear pulse wrong");
    property p_off_ignores;
        @(posedge i_clock) disable iff (i_sys_rst)
        !converter_on && !(i_wr_stb && i_addr == OFS_ADC_CONTROL_MAIN) |=> !convert_go && state == ACS_IDLE;
    endproperty
    a_off_ignores: assert property (p_off_ignores) else $error("converter off but go or busy");
    property p_reset_state;
        @(posedge i_clock) i_sys_rst |=> state == ACS_IDLE && adc_control_main == RST_CONTROL && !o_converter_powered;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset did not clear converter");
    property p_early_halt;
        @(posedge i_clock) disable iff (i_sys_rst)
        state == ACS_CONVERT && !convert_go && !sleep_abort
        |=> state == ACS_IDLE && result_high_byte == $past(fmt_result(sar, adc_control_config[CFG_RIGHT_JUSTIFY]) >> 8);
    endproperty
    a_early_halt: assert property (p_early_halt) else $error("early halt result wrong");
    property p_full_length;
        @(posedge i_clock) disable iff (i_sys_rst)
        state == ACS_CONVERT ##1 state == ACS_DONE_WAIT |-> conv_tads == FULL_CONV_TADS;
    endproperty
    a_full_length: assert property (p_full_length) else $error("conversion length not 13 periods");
    property p_flag_then_go;
        @(posedge i_clock) disable iff (i_sys_rst)
        finish |=> peripheral_irq_flags[PIR_CONV_DONE_IRQ_FLAG] && convert_go ##1 !convert_go;
    endproperty
    a_flag_then_go: assert property (p_flag_then_go) else $error("flag or go order wrong");
    property p_rc_wait;
        @(posedge i_clock) disable iff (i_sys_rst)
        state == ACS_SETTLE && $past(state) == ACS_RC_WAIT |-> $past(rc_cnt) == RC_WAIT_LAST;
    endproperty
    a_rc_wait: assert property (p_rc_wait) else $error("RC wait not one instruction cycle");
    property p_sleep_abort;
        @(posedge i_clock) disable iff (i_sys_rst)
        sleep_abort |=> state == ACS_IDLE && !convert_go && converter_on && !o_converter_powered;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort wrong");
    property p_sleep_finish;
        @(posedge i_clock) disable iff (i_sys_rst)
        finish && i_sleep |=> (conv_done_irq_enable ? o_wake : (!o_converter_powered && converter_on));
    endproperty
    a_sleep_finish: assert property (p_sleep_finish) else $error("sleep finish wake or power wrong");
    c_full_conv:    cover property (@(posedge i_clock) disable iff (i_sys_rst) finish);
    c_trigger_run:  cover property (@(posedge i_clock) disable iff (i_sys_rst) trig_act && converter_on);
    c_early_halt:   cover property (@(posedge i_clock) disable iff (i_sys_rst) state == ACS_CONVERT && !convert_go);
    c_sleep_wake:   cover property (@(posedge i_clock) disable iff (i_sys_rst) finish && i_sleep);
endmodule // acs_conversion_sequencer

/* rtl/acs_pkg.sv */
package acs_pkg;

    // Register port
    localparam int unsigned ADDR_W                 = 8;
    localparam int unsigned DATA_W                 = 8;
    localparam logic [7:0]  OFS_INTERRUPT_CONTROL  = 8'h0b;
    localparam logic [7:0]  OFS_PERIPH_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0]  OFS_ADC_RESULT_HIGH    = 8'h1e;
    localparam logic [7:0]  OFS_ADC_CONTROL_MAIN   = 8'h1f;
    localparam logic [7:0]  OFS_PERIPH_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0]  OFS_VREF_CONTROL       = 8'h9b;
    localparam logic [7:0]  OFS_ADC_RESULT_LOW     = 8'h9e;
    localparam logic [7:0]  OFS_ADC_CONTROL_CONFIG = 8'h9f;

    // Reset value and vref implemented-bit write mask
    localparam logic [7:0]  RST_CONTROL            = 8'h00;
    localparam logic [7:0]  VREF_IMPL_MASK         = 8'hf0;

    // Field positions in adc_control_main
    localparam int unsigned CM_CONVERTER_ON        = 0;
    localparam int unsigned CM_CHANNEL_SELECT_HI   = 1;
    localparam int unsigned CM_CONVERT_GO          = 2;
    localparam int unsigned CM_CHANNEL_SELECT_LO   = 3;
    localparam int unsigned CM_CONV_CLOCK_SELECT   = 6;

    // Other field positions
    localparam int unsigned PIR_CONV_DONE_IRQ_FLAG = 6;
    localparam int unsigned PIE_CONV_DONE_IRQ_EN   = 6;
    localparam int unsigned CFG_RIGHT_JUSTIFY      = 7;

    // Compare module trigger mode
    localparam logic [3:0]  TRIGGER_MODE_CODE      = 4'hb;

    // Conversion clock select codes and divider masks (oscillator periods minus one)
    localparam logic [1:0]  CLKSEL_DIV2            = 2'h0;
    localparam logic [1:0]  CLKSEL_DIV8            = 2'h1;
    localparam logic [1:0]  CLKSEL_DIV32           = 2'h2;
    localparam logic [1:0]  CLKSEL_RC              = 2'h3;
    localparam logic [4:0]  DIV2_MASK              = 5'h01;
    localparam logic [4:0]  DIV8_MASK              = 5'h07;
    localparam logic [4:0]  DIV32_MASK             = 5'h1f;

    // Timing
    localparam int unsigned CLK_PERIOD_NS          = 20;
    localparam int unsigned QUARTERS_PER_INSTR     = 4;
    localparam logic [1:0]  SECOND_QUARTER_PHASE   = 2'h1;
    localparam logic [1:0]  RC_WAIT_LAST           = 2'(QUARTERS_PER_INSTR - 1);
    localparam int unsigned RESULT_BITS            = 12;
    localparam int unsigned SETTLE_TADS            = 1;
    localparam logic [3:0]  FULL_CONV_TADS         = 4'(SETTLE_TADS + RESULT_BITS);
    localparam logic [11:0] FIRST_TRIAL_BIT        = 12'h0800;

    typedef enum logic [2:0] {
        ACS_IDLE,
        ACS_RC_WAIT,
        ACS_SETTLE,
        ACS_CONVERT,
        ACS_DONE_WAIT,
        ACS_FINISH
    } acs_state_e;

endpackage

/* verification/acs_far_side_model.sv */
`timescale 1ns/10ps
module acs_far_side_model
    import acs_pkg::*;
(
    // Clock
    input  wire logic        i_clock,
    // Analog side
    input  wire logic [11:0] i_dac_code,
    input  wire logic [11:0] i_level,
    output logic             o_cmp_high,
    // Compare module and RC source
    input  wire logic        i_fire,
    output logic             o_special_event,
    output logic             o_rc_tick
);
    logic [2:0] rc_div = 3'h0;
    logic       ev     = 1'b0;
    logic       tick   = 1'b0;
    // Ideal comparator, input held steady for the whole conversion
    assign o_cmp_high      = (i_level >= i_dac_code);
    assign o_special_event = ev;
    assign o_rc_tick       = tick;
    // RC period of six clocks, deliberately unrelated to the dividers
    always_ff @(posedge i_clock) begin
        ev     <= i_fire;
        rc_div <= (rc_div == 3'h5) ? 3'h0 : rc_div + 3'h1;
        tick   <= (rc_div == 3'h5);
    end
endmodule // acs_far_side_model

/* verification/adc_conversion_sequencer_tb_top.sv */
`timescale 1ns/10ps
module adc_conversion_sequencer_tb_top
    import acs_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sleep = 1'b0;
    logic        fire = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic [3:0]  mode = 4'h0;
    logic [11:0] level = 12'ha5c;
    logic [7:0]  rdata;
    logic [11:0] dac;
    logic        cmp, sev, rct, clr, pwr, wake;
    int          fails = 0, checked = 0, n_clr = 0, n_wake = 0;
    logic [7:0]  ofs [7] = '{OFS_PERIPH_IRQ_FLAGS, OFS_ADC_CONTROL_MAIN, OFS_PERIPH_IRQ_ENABLES,
                            OFS_VREF_CONTROL, OFS_ADC_CONTROL_CONFIG, OFS_INTERRUPT_CONTROL, 8'h40};

    acs_conversion_sequencer dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr_data(wd),
        .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdata), .i_compare_mode_select(mode), .i_special_event(sev),
        .o_ref_counter_clear(clr), .i_sleep(sleep), .i_rc_tick(rct), .o_converter_powered(pwr),
        .o_wake(wake), .i_cmp_high(cmp), .o_dac_code(dac));
    acs_far_side_model far (.i_clock(i_clock), .i_dac_code(dac), .i_level(level), .o_cmp_high(cmp),
        .i_fire(fire), .o_special_event(sev), .o_rc_tick(rct));

    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (clr === 1'b1) n_clr++;
        if (wake === 1'b1) n_wake++;
    end

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_idle(input int lim, output logic [7:0] d);
        for (int k = 0; k < lim; k++) begin
            rd_reg(OFS_ADC_CONTROL_MAIN, d);
            if (d[CM_CONVERT_GO] === 1'b0) break;
        end
    endtask
    task automatic trig(input logic [3:0] m);
        @(posedge i_clock);
        mode <= m;
        fire <= 1'b1;
        @(posedge i_clock);
        fire <= 1'b0;
        repeat (8) @(posedge i_clock);
    endtask
    task automatic rd_res(output logic [7:0] h, output logic [7:0] l);
        rd_reg(OFS_ADC_RESULT_HIGH, h);
        rd_reg(OFS_ADC_RESULT_LOW, l);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        print_verdict();
    end

    initial begin
        logic [7:0] d, h, l;
        int c, w;
        logic hit;
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        foreach (ofs[k]) begin
            rd_reg(ofs[k], d);
            chk("reset value", 12'(d), 12'h000);
        end
        wr_reg(OFS_VREF_CONTROL, 8'hff);
        rd_reg(OFS_VREF_CONTROL, d);
        chk("vref bits", 12'(d), 12'(VREF_IMPL_MASK));
        wr_reg(OFS_INTERRUPT_CONTROL, 8'ha5);
        rd_reg(OFS_INTERRUPT_CONTROL, d);
        chk("irq control store", 12'(d), 12'h0a5);
        @(posedge i_clock);
        #1 chk("read idle", 12'(rdata), 12'h000);
        $display("registers done");
        // Full conversion at divide by 2, right justified
        wr_reg(OFS_ADC_CONTROL_CONFIG, 8'h80);
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h01);
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h05);
        repeat (20) @(posedge i_clock);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("go early", 12'(d[CM_CONVERT_GO]), 12'h001);
        wait_idle(10, d);
        chk("go done", 12'(d[CM_CONVERT_GO]), 12'h000);
        rd_reg(OFS_PERIPH_IRQ_FLAGS, d);
        chk("done flag", 12'(d[PIR_CONV_DONE_IRQ_FLAG]), 12'h001);
        rd_res(h, l);
        chk("result", {h[3:0], l}, level);
        wr_reg(OFS_ADC_CONTROL_CONFIG, 8'h00);
        $display("conversion done");
        // Trigger: channel already chosen, then on, wrong mode, off
        c = n_clr;
        trig(TRIGGER_MODE_CODE);
        chk("clear pulse", 12'(n_clr - c), 12'h001);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("trigger go", 12'(d[CM_CONVERT_GO]), 12'h001);
        wait_idle(20, d);
        trig(4'h0);
        chk("wrong mode", 12'(n_clr - c), 12'h001);
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h00);
        trig(TRIGGER_MODE_CODE);
        chk("off clear", 12'(n_clr - c), 12'h002);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("off go", 12'(d), 12'h000);
        $display("trigger done");
        // Early halt, timed by the bench at divide by 32
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h85);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("go with on refused", 12'(d), 12'h081);
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h85);
        repeat (192) @(posedge i_clock);
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h81);
        rd_res(h, l);
        hit = 1'b0;
        for (int n = 1; n < 12; n++) if ({h, l[7:4]} === (level & (12'hfff << (12 - n)))) hit = 1'b1;
        chk("partial result", 12'(hit), 12'h001);
        chk("low pad", 12'(l[3:0]), 12'h000);
        $display("early halt done");
        // Sleep with RC clock, wake enabled then disabled
        for (int e = 1; e >= 0; e--) begin
            w = n_wake;
            wr_reg(OFS_PERIPH_IRQ_ENABLES, e[0] ? 8'h40 : 8'h00);
            wr_reg(OFS_ADC_CONTROL_MAIN, 8'hc5);
            sleep <= 1'b1;
            wait_idle(150, d);
            chk("sleep go", 12'(d[2:0]), 12'h001);
            chk("wake", 12'(n_wake - w), 12'(e));
            if (e == 0) chk("powered", 12'(pwr), 12'h000);
            rd_res(h, l);
            chk("sleep result", {h, l[7:4]}, level);
            sleep <= 1'b0;
        end
        // Sleep with a divided clock aborts
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h45);
        repeat (20) @(posedge i_clock);
        sleep <= 1'b1;
        repeat (4) @(posedge i_clock);
        #1 chk("abort power", 12'(pwr), 12'h000);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("abort bits", 12'(d[2:0]), 12'h001);
        sleep <= 1'b0;
        $display("sleep done");
        // Reset mid-conversion keeps result bytes
        wr_reg(OFS_ADC_CONTROL_MAIN, 8'h45);
        repeat (30) @(posedge i_clock);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        #1 chk("reset code", dac, 12'h000);
        rd_reg(OFS_ADC_CONTROL_MAIN, d);
        chk("reset main", 12'(d), 12'h000);
        rd_res(h, l);
        chk("kept result", {h, l[7:4]}, level);
        $display("reset done");
        print_verdict();
    end
endmodule // adc_conversion_sequencer_tb_top
